// ### dv/output_driver_protect_ctrl_monitor.sv
// assertion checker for the output driver protection register bank
`timescale 1ns/1ps

module output_driver_protect_ctrl_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  // detectors and outputs
  input wire logic       hp_short_pin,
  input wire logic       spk_short_pin,
  input wire logic       left_headphone_driver_en,
  input wire logic       left_speaker_driver_en,
  input wire logic [1:0] hp_common_mode_sel,
  input wire logic       hp_current_limit,
  input wire logic       irq
);
  // ---------------------------------------------------------------------------
  // shadow of software-owned fields
  // ---------------------------------------------------------------------------
  logic [7:0] pg_m;
  logic [1:0] pol_m;
  logic       hpsd_m;
  logic [1:0] cm_m;
  logic [3:0] mask_m;
  wire        wp = wr_en && (pg_m == 8'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_m <= 8'h00;
      pol_m <= 2'h0;
      hpsd_m <= 1'b0;
      cm_m <= 2'h0;
      mask_m <= 4'h0;
    end else begin
      if (wr_en && addr == 8'h00) pg_m <= wdata;
      if (wp && addr == 8'h1e) pol_m <= wdata[1:0];
      if (wp && addr == 8'h1f) hpsd_m <= wdata[1];
      if (wp && addr == 8'h1f) cm_m <= wdata[4:3];
      if (wp && addr == 8'h22) mask_m <= wdata[3:0];
    end
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("rdata not idle");
  page_read_a: assert property (rd_en && addr == 8'h00 |=> rdata == $past(pg_m))
    else $error("page readback wrong");
  cm_out_a: assert property (hp_common_mode_sel == $past(cm_m))
    else $error("common mode output wrong");
  hp_on_cause_a: assert property ($rose(left_headphone_driver_en) |->
    $past(wr_en, 2) && $past(addr, 2) == 8'h1f) else $error("hp driver on without write");
  spk_on_cause_a: assert property ($rose(left_speaker_driver_en) |->
    $past(wr_en, 2) && $past(addr, 2) == 8'h20) else $error("spk driver on without write");
  hp_trip_a: assert property ($rose(hp_short_pin) && hpsd_m && !pol_m[1]
    |-> ##[3:6] !left_headphone_driver_en) else $error("hp short did not trip");
  hp_keep_a: assert property ($rose(hp_short_pin) && pol_m[1] && left_headphone_driver_en
    |=> left_headphone_driver_en [*6]) else $error("hp driver dropped in keep mode");
  spk_trip_a: assert property ($rose(spk_short_pin) && !pol_m[0]
    |-> ##[3:6] !left_speaker_driver_en) else $error("spk short did not trip");
  limit_on_a: assert property ($rose(hp_short_pin) && !hpsd_m
    |-> ##[2:5] hp_current_limit) else $error("current limit not raised");
  irq_mask_a: assert property (mask_m == 4'h0 |=> !irq) else $error("masked irq raised");
  trip_c: cover property ($fell(left_speaker_driver_en));
  limit_c: cover property ($rose(hp_current_limit));
  irq_c: cover property ($rose(irq));
endmodule // output_driver_protect_ctrl_monitor

bind output_driver_protect_ctrl
  output_driver_protect_ctrl_monitor i_output_driver_protect_ctrl_monitor (
  .clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .hp_short_pin, .spk_short_pin,
  .left_headphone_driver_en, .left_speaker_driver_en, .hp_common_mode_sel,
  .hp_current_limit, .irq);

// ### dv/tb.sv
// self-checking testbench for the output driver protection register bank
`timescale 1ns/1ps

module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rdata;
  logic       hp_pin = 1'b0;
  logic       spk_pin = 1'b0;
  logic       hl, hr, sl, sr, lim, irq;
  logic [1:0] cm;
  logic [7:0] page_sel;
  int         n_mismatch = 0;
  int         total_checks = 0;

  always #12.5 clk = ~clk;

  output_driver_protect_ctrl i_output_driver_protect_ctrl (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .hp_short_pin(hp_pin), .spk_short_pin(spk_pin),
    .left_headphone_driver_en(hl), .right_headphone_driver_en(hr),
    .left_speaker_driver_en(sl), .right_speaker_driver_en(sr), .hp_common_mode_sel(cm),
    .hp_current_limit(lim), .page_sel(page_sel), .irq(irq));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // callers keep clear of offsets 1 to 29 while page 1 is selected
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  // detector level changes land off the sampling edge; 5 edges cover sync plus output flop
  task automatic pins(input logic h, input logic s);
    @(posedge clk);
    hp_pin <= h;
    spk_pin <= s;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 8'h00, "page reset");
    rd(8'h1f, 8'h00, "hp off page");
    wr(8'h00, 8'h01);
    rd(8'h1e, 8'h00, "policy reset");
    rd(8'h1f, 8'h04, "hp reset");
    rd(8'h20, 8'h06, "spk reset");
    rd(8'h22, 8'h00, "mask reset");
    rd(8'h23, 8'h00, "unmapped");
    wr(8'h1e, 8'hfc);
    rd(8'h1e, 8'hfc, "policy reserved rw");
    wr(8'h1e, 8'h00);
    chk("page_sel", 8'h01, page_sel);
  endtask
  task automatic t_page;
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hff, "page max");
    rd(8'h1e, 8'h00, "policy off page");
    chk("page_sel max", 8'hff, page_sel);
    wr(8'h00, 8'h01);
  endtask
  task automatic t_fields;
    for (int c = 0; c < 4; c++) begin
      wr(8'h1f, {3'b110, c[1:0], 3'b101});
      rd(8'h1f, {3'b110, c[1:0], 3'b100}, "hp fields");
      chk("cm sel", {6'h00, c[1:0]}, {6'h00, cm});
      chk("hp en", 8'h03, {6'h00, hl, hr});
    end
    wr(8'h1f, 8'h04);
    rd(8'h1f, 8'h04, "hp off");
    chk("hp en off", 8'h00, {6'h00, hl, hr});
  endtask
  task automatic t_hp;
    wr(8'h1f, 8'hc4);
    pins(1'b1, 1'b0);
    chk("limit on", 8'h01, {7'h00, lim});
    rd(8'h1f, 8'hc5, "hp limit short");
    pins(1'b0, 1'b0);
    rd(8'h1f, 8'hc4, "hp short gone");
    rd(8'h21, 8'h01, "status hp onset");
    wr(8'h1f, 8'hc6);
    pins(1'b1, 1'b0);
    chk("hp tripped", 8'h00, {6'h00, hl, hr});
    rd(8'h1f, 8'h07, "hp trip readback");
    rd(8'h21, 8'h05, "status hp trip");
    pins(1'b0, 1'b0);
    rd(8'h1f, 8'h06, "hp stays off");
    wr(8'h1e, 8'h02);
    wr(8'h1f, 8'hc6);
    pins(1'b1, 1'b0);
    chk("hp kept", 8'h03, {6'h00, hl, hr});
    rd(8'h1f, 8'hc7, "hp keep readback");
    pins(1'b0, 1'b0);
    rd(8'h21, 8'h01, "status hp keep");
  endtask
  task automatic t_spk;
    wr(8'h1e, 8'h00);
    wr(8'h20, 8'hc6);
    pins(1'b0, 1'b1);
    chk("spk tripped", 8'h00, {6'h00, sl, sr});
    rd(8'h20, 8'h06, "spk trip readback");
    rd(8'h21, 8'h0a, "status spk trip");
    pins(1'b0, 1'b0);
    wr(8'h1e, 8'h01);
    wr(8'h20, 8'hc6);
    pins(1'b0, 1'b1);
    chk("spk kept", 8'h03, {6'h00, sl, sr});
    rd(8'h20, 8'hc7, "spk keep flag");
    pins(1'b0, 1'b0);
    rd(8'h21, 8'h02, "status spk keep");
  endtask
  task automatic t_irq;
    // limit mode and drivers off, so only the onset event reaches status
    wr(8'h1f, 8'h04);
    wr(8'h22, 8'h0f);
    rd(8'h22, 8'h0f, "mask rw");
    pins(1'b1, 1'b0);
    chk("irq up", 8'h01, {7'h00, irq});
    rd(8'h21, 8'h01, "status clear");
    repeat (2) @(posedge clk);
    #1;
    chk("irq down", 8'h00, {7'h00, irq});
    pins(1'b0, 1'b0);
    wr(8'h22, 8'h00);
    pins(1'b1, 1'b0);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(8'h21, 8'h01, "status masked");
    pins(1'b0, 1'b0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_page;
    t_fields;
    t_hp;
    t_spk;
    t_irq;
    stop_test;
  end
endmodule // tb

// ### verilog/drv_protect_pkg.sv
// types shared by the output driver protection block
package drv_protect_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic [2:0] {
    PROT_IDLE  = 3'b001,
    PROT_LIMIT = 3'b010,
    PROT_TRIP  = 3'b100
  } prot_state_t;

endpackage

// ### verilog/drv_protect_regs.svh
// register offsets, field positions and reset values of the output driver protection block
`ifndef DRV_PROTECT_REGS_SVH
`define DRV_PROTECT_REGS_SVH

// ----------------------------------------------------------------------------
// offsets (8-bit register index on the control port)
// ----------------------------------------------------------------------------
`define OFS_PAGE_SELECT      8'h00
`define OFS_FAULT_POLICY     8'h1e
`define OFS_HP_DRIVER_CTRL   8'h1f
`define OFS_SPK_AMP_CTRL     8'h20
`define OFS_IRQ_STATUS       8'h21
`define OFS_IRQ_MASK         8'h22

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_LEFT_PWR         7
`define BIT_RIGHT_PWR        6
`define BIT_HP_RSVD_ZERO     5
`define FLD_CM_HI            4
`define FLD_CM_LO            3
`define BIT_HP_RSVD_ONE      2
`define BIT_HP_SHUTDOWN      1
`define BIT_SHORT_FLAG       0
`define BIT_POL_HP_KEEP      1
`define BIT_POL_SPK_KEEP     0
`define BIT_IRQ_HP_SHORT     0
`define BIT_IRQ_SPK_SHORT    1
`define BIT_IRQ_HP_TRIP      2
`define BIT_IRQ_SPK_TRIP     3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_PAGE_SELECT      8'h00
`define RST_FAULT_POLICY     8'h00
`define RST_HP_DRIVER_CTRL   8'h04
`define RST_SPK_AMP_CTRL     8'h06
`define RST_IRQ_MASK         8'h00
`define PAGE_FOR_DRIVERS     8'h01

`endif

// ### verilog/output_driver_protect_ctrl.sv
// register bank for headphone and speaker driver power-up and short-circuit protection
`timescale 1ns/1ps
`include "drv_protect_regs.svh"

module output_driver_protect_ctrl
  import drv_protect_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // short-circuit detectors from the analog drivers
  input  wire logic       hp_short_pin,
  input  wire logic       spk_short_pin,
  // driver controls
  output logic            left_headphone_driver_en,
  output logic            right_headphone_driver_en,
  output logic            left_speaker_driver_en,
  output logic            right_speaker_driver_en,
  output logic      [1:0] hp_common_mode_sel,
  output logic            hp_current_limit,
  output logic      [7:0] page_sel,
  // interrupt
  output logic            irq
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  reg8_t       page_reg;
  reg8_t       policy_reg;
  reg8_t       hp_ctrl_reg;
  reg8_t       spk_ctrl_reg;
  reg8_t       irq_status_reg;
  reg8_t       irq_mask_reg;
  reg8_t       rdata_next;
  prot_state_t hp_state_reg;
  logic        hp_level;
  logic        hp_rise;
  logic        spk_level;
  logic        spk_rise;
  logic        driver_page;
  logic        wr_policy;
  logic        wr_hp;
  logic        wr_spk;
  logic        wr_mask;
  logic        rd_status;
  logic        hp_trip;
  logic        spk_trip;
  logic        spk_power_next;
  logic [1:0]  short_pin_vec;
  logic [1:0]  short_level_vec;
  logic [1:0]  short_rise_vec;

  // --------------------------------------------------------------------------
  // detector synchronisers
  // --------------------------------------------------------------------------
  // index 0 headphone, index 1 speaker; one synchroniser per detector
  assign short_pin_vec = {spk_short_pin, hp_short_pin};

  for (genvar i = 0; i < 2; i++) begin : g_short_sync
    short_detect_sync i_short_detect_sync (
      .clk         (clk),
      .rst_n       (rst_n),
      .short_pin   (short_pin_vec[i]),
      .short_level (short_level_vec[i]),
      .short_rise  (short_rise_vec[i])
    );
  end

  assign hp_level  = short_level_vec[0];
  assign hp_rise   = short_rise_vec[0];
  assign spk_level = short_level_vec[1];
  assign spk_rise  = short_rise_vec[1];

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // driver registers live on page 1; other pages are outside this block
  assign driver_page = (page_reg == `PAGE_FOR_DRIVERS);
  assign wr_policy   = wr_en & driver_page & (addr == `OFS_FAULT_POLICY);
  assign wr_hp       = wr_en & driver_page & (addr == `OFS_HP_DRIVER_CTRL);
  assign wr_spk      = wr_en & driver_page & (addr == `OFS_SPK_AMP_CTRL);
  assign wr_mask     = wr_en & driver_page & (addr == `OFS_IRQ_MASK);
  assign rd_status   = rd_en & driver_page & (addr == `OFS_IRQ_STATUS);

  // power state after this edge, so the flag never reads 1 beside cleared power bits
  always_comb begin
    spk_power_next = spk_ctrl_reg[`BIT_LEFT_PWR] | spk_ctrl_reg[`BIT_RIGHT_PWR];
    if (wr_spk) begin
      spk_power_next = wdata[`BIT_LEFT_PWR] | wdata[`BIT_RIGHT_PWR];
    end
    if (spk_trip) begin
      spk_power_next = 1'b0;
    end
  end

  // shutdown policy: a trip fires only on a fresh detection, so a later
  // software re-enable is not immediately undone by a lingering level
  assign hp_trip  = hp_rise & hp_ctrl_reg[`BIT_HP_SHUTDOWN]
                  & ~policy_reg[`BIT_POL_HP_KEEP];
  assign spk_trip = spk_rise & ~policy_reg[`BIT_POL_SPK_KEEP];

  // --------------------------------------------------------------------------
  // page select
  // --------------------------------------------------------------------------
  // page register answers on every page, as offset 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `RST_PAGE_SELECT;
    end else if (wr_en && addr == `OFS_PAGE_SELECT) begin
      page_reg <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // fault policy
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      policy_reg <= `RST_FAULT_POLICY;
    end else if (wr_policy) begin
      policy_reg <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // headphone driver control
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_ctrl_reg <= `RST_HP_DRIVER_CTRL;
    end else begin
      if (wr_hp) begin
        // bits 7:1 stored as written; host keeps 5 low and 2 high
        hp_ctrl_reg[7:1] <= wdata[7:1];
      end
      // trip wins over a same-cycle write of the power bits
      if (hp_trip) begin
        hp_ctrl_reg[`BIT_LEFT_PWR]  <= 1'b0;
        hp_ctrl_reg[`BIT_RIGHT_PWR] <= 1'b0;
      end
      hp_ctrl_reg[`BIT_SHORT_FLAG] <= hp_level;
    end
  end

  // --------------------------------------------------------------------------
  // speaker amplifier control
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spk_ctrl_reg <= `RST_SPK_AMP_CTRL;
    end else begin
      if (wr_spk) begin
        spk_ctrl_reg[7:1] <= wdata[7:1];
      end
      if (spk_trip) begin
        spk_ctrl_reg[`BIT_LEFT_PWR]  <= 1'b0;
        spk_ctrl_reg[`BIT_RIGHT_PWR] <= 1'b0;
      end
      // flag only carries meaning with the amplifier up
      spk_ctrl_reg[`BIT_SHORT_FLAG] <= spk_level & spk_power_next;
    end
  end

  // --------------------------------------------------------------------------
  // headphone protection state
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_state_reg <= PROT_IDLE;
    end else begin
      case (hp_state_reg)
        PROT_IDLE: begin
          if (hp_trip) begin
            hp_state_reg <= PROT_TRIP;
          end else if (hp_level && !hp_ctrl_reg[`BIT_HP_SHUTDOWN]) begin
            hp_state_reg <= PROT_LIMIT;
          end
        end
        PROT_LIMIT: begin
          if (hp_trip) begin
            hp_state_reg <= PROT_TRIP;
          end else if (!hp_level || hp_ctrl_reg[`BIT_HP_SHUTDOWN]) begin
            hp_state_reg <= PROT_IDLE;
          end
        end
        PROT_TRIP: begin
          // driver stays off until software raises a power bit again
          if (wr_hp && (wdata[`BIT_LEFT_PWR] || wdata[`BIT_RIGHT_PWR])) begin
            hp_state_reg <= PROT_IDLE;
          end
        end
        default: begin
          hp_state_reg <= PROT_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // driver outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_headphone_driver_en  <= 1'b0;
      right_headphone_driver_en <= 1'b0;
      left_speaker_driver_en    <= 1'b0;
      right_speaker_driver_en   <= 1'b0;
      hp_common_mode_sel        <= 2'h0;
      hp_current_limit          <= 1'b0;
      page_sel                  <= `RST_PAGE_SELECT;
    end else begin
      left_headphone_driver_en  <= hp_ctrl_reg[`BIT_LEFT_PWR];
      right_headphone_driver_en <= hp_ctrl_reg[`BIT_RIGHT_PWR];
      left_speaker_driver_en    <= spk_ctrl_reg[`BIT_LEFT_PWR];
      right_speaker_driver_en   <= spk_ctrl_reg[`BIT_RIGHT_PWR];
      hp_common_mode_sel        <= hp_ctrl_reg[`FLD_CM_HI:`FLD_CM_LO];
      hp_current_limit          <= (hp_state_reg == PROT_LIMIT);
      page_sel                  <= page_reg;
    end
  end

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  // an event in the same cycle as the clearing read is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 8'h00;
    end else begin
      irq_status_reg <= (rd_status ? 8'h00 : irq_status_reg)
                      | {4'h0, spk_trip, hp_trip, spk_rise, hp_rise};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= `RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_reg <= {4'h0, wdata[3:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (addr == `OFS_PAGE_SELECT) begin
      rdata_next = page_reg;
    end else if (driver_page) begin
      case (addr)
        `OFS_FAULT_POLICY:   rdata_next = policy_reg;
        `OFS_HP_DRIVER_CTRL: rdata_next = hp_ctrl_reg;
        `OFS_SPK_AMP_CTRL:   rdata_next = spk_ctrl_reg;
        `OFS_IRQ_STATUS:     rdata_next = irq_status_reg;
        `OFS_IRQ_MASK:       rdata_next = irq_mask_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // output_driver_protect_ctrl

// ### verilog/short_detect_sync.sv
// two-stage synchroniser and rising-edge detect for one short-circuit detector
`timescale 1ns/1ps

module short_detect_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // detector pin
  input  wire logic short_pin,
  // synchronised level and onset pulse
  output logic      short_level,
  output logic      short_rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= short_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign short_level = sync_reg;
  assign short_rise  = sync_reg & ~last_reg;

endmodule // short_detect_sync
